// >>> nfpc_pkg.sv
package nfpc_pkg;

  // Bus timing of the flash write and read strobes
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_WP_NS = 35;
  localparam int T_WPH_NS = 20;
  localparam int T_ACC_NS = 70;
  localparam int SYNC_CYC = 3;
  localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WPH_CYC = (T_WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] WP_LOAD = 4'(WP_CYC - 1);
  localparam logic [3:0] WPH_LOAD = 4'(WPH_CYC - 1);
  localparam logic [3:0] ACC_LOAD = 4'(ACC_CYC + SYNC_CYC - 1);

  // Register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ADDR = 8'h08;
  localparam logic [7:0] REG_DATA = 8'h0C;
  localparam logic [7:0] REG_COUNT = 8'h10;
  localparam logic [7:0] REG_BUFPTR = 8'h14;
  localparam logic [7:0] REG_BUFDATA = 8'h18;
  localparam logic [7:0] REG_RDDATA = 8'h1C;
  localparam int CTRL_HV_BIT = 8;
  localparam int CTRL_SUS_BIT = 9;

  // Operation codes written to the low nibble of the control register
  localparam logic [3:0] OP_NONE = 4'h0;
  localparam logic [3:0] OP_BYP_ENTER = 4'h1;
  localparam logic [3:0] OP_BYP_EXIT = 4'h2;
  localparam logic [3:0] OP_PROGRAM = 4'h3;
  localparam logic [3:0] OP_BUF_PROGRAM = 4'h4;
  localparam logic [3:0] OP_READ_RESET = 4'h5;
  localparam logic [3:0] OP_ABORT_RESET = 4'h6;
  localparam logic [3:0] OP_READ = 4'h7;
  localparam logic [3:0] OP_SUSPEND = 4'h8;

  // Sequence steps of one operation
  localparam logic [2:0] SEQ_UNL1 = 3'h0;
  localparam logic [2:0] SEQ_UNL2 = 3'h1;
  localparam logic [2:0] SEQ_CMD = 3'h2;
  localparam logic [2:0] SEQ_ARG = 3'h3;
  localparam logic [2:0] SEQ_LOAD = 3'h4;
  localparam logic [2:0] SEQ_CONF = 3'h5;
  localparam logic [2:0] SEQ_POLL = 3'h6;
  localparam logic [2:0] SEQ_END = 3'h7;

  // Flash command words and unlock addresses
  localparam logic [22:0] UNLOCK_ADDR1 = 23'h000555;
  localparam logic [22:0] UNLOCK_ADDR2 = 23'h0002AA;
  localparam logic [15:0] CMD_UNLOCK1 = 16'h00AA;
  localparam logic [15:0] CMD_UNLOCK2 = 16'h0055;
  localparam logic [15:0] CMD_BYP_ENTER = 16'h0020;
  localparam logic [15:0] CMD_PROGRAM = 16'h00A0;
  localparam logic [15:0] CMD_BUF_PROGRAM = 16'h0025;
  localparam logic [15:0] CMD_CONFIRM = 16'h0029;
  localparam logic [15:0] CMD_RESET = 16'h00F0;
  localparam logic [15:0] CMD_BYP_RST1 = 16'h0090;
  localparam logic [15:0] CMD_BYP_RST2 = 16'h0000;
  localparam logic [15:0] CMD_SUSPEND = 16'h00B0;
  localparam logic [9:0] PAGE_LAST = 10'h1FF;

  // Status bit positions inside the polling word
  localparam int POLL_ABORT_BIT = 1;
  localparam int POLL_ERROR_BIT = 5;
  localparam int POLL_TOGGLE_BIT = 6;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic dq_oe;
    logic [22:0] addr;
    logic [15:0] dq_out;
  } nfpc_pins_type;

  localparam nfpc_pins_type PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_oe: 1'b0,
                                          addr: 23'h000000, dq_out: 16'h0000};

endpackage

// >>> nfpc_ctrl.sv
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
// Overview of operation
// - Enter unlock bypass with three writes ending in code 20h.
// - Host prefers commands; raises high voltage only with device in read mode.
// - Leave bypass with two writes, 90h then 00h.
// - After a failure the host issues read/reset to clear the error.
// - In bypass, program A0h takes only two writes.
// - Buffer order: unlocks, setup, count n, then n+1 address/data pairs.
// - All buffer addresses stay inside one 512-word page.
// - Buffer loads are followed by confirm 29h, programming n+1 words.
// - After abort, the full three-write reset ending F0h is required.
// - In bypass, buffer program takes two fewer writes.
module nfpc_ctrl (
  input wire logic pclk, // 100 MHz bus clock
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  output nfpc_pkg::nfpc_pins_type flash_pins, // Flash control, address and data out
  input wire logic [15:0] dq_in, // Flash data pins as read back
  output logic accelerate_voltage_level // Request high voltage on protect pin
);

  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_WLOW, ST_WHIGH, ST_RWAIT}
    nfpc_st_type;

  nfpc_st_type st_q;
  nfpc_pkg::nfpc_pins_type pins_q;
  logic [3:0] op_q, tmr_q;
  logic [2:0] seq_q, nxt_seq, first_seq;
  logic [8:0] idx_q, cnt_q, bptr_q;
  logic [22:0] addr_q, it_addr;
  logic [15:0] data_q, rd_q, prev_q, it_data, cmd_word, s1_q, s2_q, s3_q;
  logic [15:0] buf_mem [512];
  logic it_rd, busy_q, bypass_q, hv_q, hv_req_q, sus_req_q, poll_first_q, err_seen_q, abt_seen_q;
  logic done_q, fail_q, abort_q, rej_q, susp_q, pready_q, pslverr_q, byp_eff;
  logic wr_en, start_req, start_bad, toggling;
  logic [31:0] prdata_q;
  logic [3:0] wop;

  assign byp_eff = bypass_q | hv_q;
  assign wr_en = psel & penable & pwrite & pready_q;
  assign wop = pwdata[3:0];
  assign start_req = wr_en && paddr == nfpc_pkg::REG_CTRL && wop != nfpc_pkg::OP_NONE;
  assign toggling = rd_q[nfpc_pkg::POLL_TOGGLE_BIT] ^ prev_q[nfpc_pkg::POLL_TOGGLE_BIT];

  // Steps that each operation issues; bypass drops the two unlock writes of program and buffer program
  function automatic logic [6:0] op_mask(input logic [3:0] op, input logic byp);
    case (op)
      nfpc_pkg::OP_BYP_ENTER: op_mask = 7'h07;
      nfpc_pkg::OP_BYP_EXIT: op_mask = 7'h0C;
      nfpc_pkg::OP_PROGRAM: op_mask = byp ? 7'h4C : 7'h4F;
      nfpc_pkg::OP_BUF_PROGRAM: op_mask = byp ? 7'h7C : 7'h7F;
      nfpc_pkg::OP_READ_RESET: op_mask = 7'h04;
      nfpc_pkg::OP_ABORT_RESET: op_mask = 7'h07;
      nfpc_pkg::OP_SUSPEND: op_mask = 7'h04;
      nfpc_pkg::OP_READ: op_mask = 7'h40;
      default: op_mask = 7'h00;
    endcase
  endfunction

  function automatic logic [2:0] seek(input logic [6:0] m, input logic [2:0] lo);
    seek = nfpc_pkg::SEQ_END;
    for (int i = 6; i >= 0; i--)
    begin
      if (m[i] && 3'(i) >= lo)
        seek = 3'(i);
    end
  endfunction

  assign nxt_seq = seek(op_mask(op_q, byp_eff), 3'(seq_q + 3'h1));
  assign first_seq = seek(op_mask(wop, byp_eff), nfpc_pkg::SEQ_UNL1);

  // Refuse starts that would break the page or the bypass command set
  always_comb
  begin
    start_bad = 1'b0;
    if (wop > nfpc_pkg::OP_SUSPEND)
      start_bad = 1'b1;
    if (wop == nfpc_pkg::OP_BYP_ENTER && byp_eff)
      start_bad = 1'b1;
    if (wop == nfpc_pkg::OP_BYP_EXIT && !bypass_q)
      start_bad = 1'b1;
    if (wop == nfpc_pkg::OP_BUF_PROGRAM
        && ({1'b0, addr_q[8:0]} + {1'b0, cnt_q}) > nfpc_pkg::PAGE_LAST)
      start_bad = 1'b1;
  end

  // Command word of the current operation
  always_comb
  begin
    case (op_q)
      nfpc_pkg::OP_BYP_ENTER: cmd_word = nfpc_pkg::CMD_BYP_ENTER;
      nfpc_pkg::OP_BYP_EXIT: cmd_word = nfpc_pkg::CMD_BYP_RST1;
      nfpc_pkg::OP_PROGRAM: cmd_word = nfpc_pkg::CMD_PROGRAM;
      nfpc_pkg::OP_BUF_PROGRAM: cmd_word = nfpc_pkg::CMD_BUF_PROGRAM;
      nfpc_pkg::OP_SUSPEND: cmd_word = nfpc_pkg::CMD_SUSPEND;
      default: cmd_word = nfpc_pkg::CMD_RESET;
    endcase
  end

  // Address, data and direction of the current bus cycle
  always_comb
  begin
    it_rd = 1'b0;
    it_addr = nfpc_pkg::UNLOCK_ADDR1;
    it_data = nfpc_pkg::CMD_UNLOCK1;
    case (seq_q)
      nfpc_pkg::SEQ_UNL2:
      begin
        it_addr = nfpc_pkg::UNLOCK_ADDR2;
        it_data = nfpc_pkg::CMD_UNLOCK2;
      end
      nfpc_pkg::SEQ_CMD:
      begin
        it_data = cmd_word;
        if (op_q == nfpc_pkg::OP_BUF_PROGRAM)
          it_addr = addr_q; // Setup goes to the target block
      end
      nfpc_pkg::SEQ_ARG:
      begin
        it_addr = addr_q;
        if (op_q == nfpc_pkg::OP_PROGRAM)
          it_data = data_q;
        else if (op_q == nfpc_pkg::OP_BUF_PROGRAM)
          it_data = {7'h00, cnt_q};
        else
        begin
          it_addr = nfpc_pkg::UNLOCK_ADDR1;
          it_data = nfpc_pkg::CMD_BYP_RST2;
        end
      end
      nfpc_pkg::SEQ_LOAD:
      begin
        it_addr = addr_q + {14'h0000, idx_q};
        it_data = buf_mem[idx_q];
      end
      nfpc_pkg::SEQ_CONF:
      begin
        it_addr = addr_q;
        it_data = nfpc_pkg::CMD_CONFIRM;
      end
      nfpc_pkg::SEQ_POLL:
      begin
        it_rd = 1'b1;
        it_addr = (op_q == nfpc_pkg::OP_BUF_PROGRAM) ? addr_q + {14'h0000, cnt_q} : addr_q;
      end
      default: it_rd = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer and bus cycle engine; polls the toggle bit after each program
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= ST_IDLE;
      op_q <= nfpc_pkg::OP_NONE;
      seq_q <= nfpc_pkg::SEQ_UNL1;
      idx_q <= 9'h000;
      tmr_q <= 4'h0;
      pins_q <= nfpc_pkg::PINS_IDLE;
      busy_q <= 1'b0;
      bypass_q <= 1'b0;
      poll_first_q <= 1'b0;
      err_seen_q <= 1'b0;
      abt_seen_q <= 1'b0;
      done_q <= 1'b0;
      fail_q <= 1'b0;
      abort_q <= 1'b0;
      rej_q <= 1'b0;
      susp_q <= 1'b0;
      rd_q <= 16'h0000;
      prev_q <= 16'h0000;
    end
    else
    begin
      case (st_q)
        ST_IDLE:
          if (start_req && start_bad)
            rej_q <= 1'b1;
          else if (start_req)
          begin
            op_q <= wop;
            seq_q <= first_seq;
            idx_q <= 9'h000;
            busy_q <= 1'b1;
            poll_first_q <= 1'b1;
            err_seen_q <= 1'b0;
            abt_seen_q <= 1'b0;
            {done_q, fail_q, abort_q, rej_q, susp_q} <= 5'h00;
            st_q <= ST_SETUP;
          end
        ST_SETUP:
        begin
          pins_q <= '{ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b1, dq_oe: !it_rd,
                      addr: it_addr, dq_out: it_data};
          st_q <= ST_STROBE;
        end
        ST_STROBE:
        begin
          pins_q.we_n <= it_rd;
          pins_q.oe_n <= !it_rd;
          tmr_q <= it_rd ? nfpc_pkg::ACC_LOAD : nfpc_pkg::WP_LOAD;
          st_q <= it_rd ? ST_RWAIT : ST_WLOW;
        end
        ST_WLOW:
          if (tmr_q != 4'h0)
            tmr_q <= tmr_q - 4'h1;
          else
          begin
            pins_q.we_n <= 1'b1;
            tmr_q <= nfpc_pkg::WPH_LOAD;
            st_q <= ST_WHIGH;
          end
        ST_RWAIT:
          if (tmr_q != 4'h0)
            tmr_q <= tmr_q - 4'h1;
          else if (s2_q == s3_q)
          begin
            rd_q <= s3_q;
            prev_q <= rd_q;
            pins_q.oe_n <= 1'b1;
            tmr_q <= nfpc_pkg::WPH_LOAD;
            st_q <= ST_WHIGH;
          end
        ST_WHIGH:
          if (tmr_q != 4'h0)
            tmr_q <= tmr_q - 4'h1;
          else
          begin
            pins_q <= nfpc_pkg::PINS_IDLE;
            st_q <= ST_SETUP;
            if (it_rd && op_q != nfpc_pkg::OP_READ)
            begin
              poll_first_q <= 1'b0;
              if (poll_first_q)
                st_q <= ST_SETUP;
              else if (!toggling)
              begin
                // Toggle stopped: done, also when a protected block ignored it
                st_q <= ST_IDLE;
                busy_q <= 1'b0;
                done_q <= 1'b1;
              end
              else if (err_seen_q && abt_seen_q)
              begin
                abort_q <= 1'b1;
                op_q <= nfpc_pkg::OP_ABORT_RESET;
                seq_q <= nfpc_pkg::SEQ_UNL1;
              end
              else if (err_seen_q)
              begin
                fail_q <= 1'b1;
                op_q <= nfpc_pkg::OP_READ_RESET;
                seq_q <= nfpc_pkg::SEQ_CMD;
              end
              else
              begin
                // A flag counts only if the next pair still toggles; array data can mimic it
                err_seen_q <= rd_q[nfpc_pkg::POLL_ERROR_BIT] | rd_q[nfpc_pkg::POLL_ABORT_BIT];
                abt_seen_q <= rd_q[nfpc_pkg::POLL_ABORT_BIT];
                if (sus_req_q)
                begin
                  op_q <= nfpc_pkg::OP_SUSPEND;
                  seq_q <= nfpc_pkg::SEQ_CMD;
                end
              end
            end
            else if (seq_q == nfpc_pkg::SEQ_LOAD && idx_q != cnt_q)
              idx_q <= idx_q + 9'h001;
            else if (nxt_seq != nfpc_pkg::SEQ_END)
              seq_q <= nxt_seq;
            else
            begin
              st_q <= ST_IDLE;
              busy_q <= 1'b0;
              done_q <= 1'b1;
              susp_q <= (op_q == nfpc_pkg::OP_SUSPEND);
              if (op_q == nfpc_pkg::OP_BYP_ENTER)
                bypass_q <= 1'b1;
              if (op_q == nfpc_pkg::OP_BYP_EXIT)
                bypass_q <= 1'b0;
            end
          end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // High voltage is raised only from idle read mode and dropped only when idle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hv_q <= 1'b0;
    else if (st_q == ST_IDLE && hv_req_q && !bypass_q && !fail_q && !abort_q)
      hv_q <= 1'b1;
    else if (st_q == ST_IDLE && !hv_req_q)
      hv_q <= 1'b0;
  end

  // Data pins pass three flops; a value counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_q <= 16'h0000;
      s2_q <= 16'h0000;
      s3_q <= 16'h0000;
    end
    else
    begin
      s1_q <= dq_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Software registers; operands may change while busy, so load them first
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hv_req_q <= 1'b0;
      sus_req_q <= 1'b0;
      addr_q <= 23'h000000;
      data_q <= 16'h0000;
      cnt_q <= 9'h000;
      bptr_q <= 9'h000;
    end
    else if (wr_en)
    begin
      case (paddr)
        nfpc_pkg::REG_CTRL:
        begin
          hv_req_q <= pwdata[nfpc_pkg::CTRL_HV_BIT];
          sus_req_q <= pwdata[nfpc_pkg::CTRL_SUS_BIT];
        end
        nfpc_pkg::REG_ADDR: addr_q <= pwdata[22:0];
        nfpc_pkg::REG_DATA: data_q <= pwdata[15:0];
        nfpc_pkg::REG_COUNT: cnt_q <= pwdata[8:0];
        nfpc_pkg::REG_BUFPTR: bptr_q <= pwdata[8:0];
        nfpc_pkg::REG_BUFDATA: bptr_q <= bptr_q + 9'h001;
        default: bptr_q <= bptr_q;
      endcase
    end
  end

  // Program buffer image; a rewritten slot simply keeps the newest word
  always_ff @(posedge pclk)
  begin
    if (wr_en && paddr == nfpc_pkg::REG_BUFDATA)
      buf_mem[bptr_q] <= pwdata[15:0];
  end

  // APB answer: one wait state, unmapped offsets return an error
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end
    else
    begin
      pready_q <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && (paddr > nfpc_pkg::REG_RDDATA || paddr[1:0] != 2'h0);
      prdata_q <= 32'h00000000;
      if (psel && penable && !pready_q && !pwrite)
        case (paddr)
          nfpc_pkg::REG_CTRL: prdata_q <= {22'h000000, sus_req_q, hv_req_q, 4'h0, op_q};
          nfpc_pkg::REG_STATUS: prdata_q <= {24'h000000, hv_q, susp_q, rej_q, abort_q,
                                             fail_q, done_q, byp_eff, busy_q};
          nfpc_pkg::REG_ADDR: prdata_q <= {9'h000, addr_q};
          nfpc_pkg::REG_DATA: prdata_q <= {16'h0000, data_q};
          nfpc_pkg::REG_COUNT: prdata_q <= {23'h000000, cnt_q};
          nfpc_pkg::REG_BUFPTR: prdata_q <= {23'h000000, bptr_q};
          nfpc_pkg::REG_RDDATA: prdata_q <= {16'h0000, rd_q};
          default: prdata_q <= 32'h00000000;
        endcase
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign flash_pins = pins_q;
  assign accelerate_voltage_level = hv_q;

  //////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_enter_byp;
    $rose(bypass_q) |-> $past(op_q) == nfpc_pkg::OP_BYP_ENTER && $past(seq_q) == nfpc_pkg::SEQ_CMD;
  endproperty
  a_enter_byp: assert property (p_enter_byp) else $error("bypass set without entry");
  property p_hv_read;
    $rose(hv_q) |-> $past(st_q) == ST_IDLE && !$past(bypass_q);
  endproperty
  a_hv_read: assert property (p_hv_read) else $error("high voltage raised outside read");
  property p_exit_byp;
    $fell(bypass_q) |-> $past(op_q) == nfpc_pkg::OP_BYP_EXIT && $past(seq_q) == nfpc_pkg::SEQ_ARG;
  endproperty
  a_exit_byp: assert property (p_exit_byp) else $error("bypass left without reset");
  property p_fail_reset;
    $rose(fail_q) |-> op_q == nfpc_pkg::OP_READ_RESET ##1 st_q == ST_STROBE;
  endproperty
  a_fail_reset: assert property (p_fail_reset) else $error("no read reset after fail");
  property p_byp_short;
    st_q == ST_STROBE && byp_eff && op_q == nfpc_pkg::OP_PROGRAM |-> seq_q >= nfpc_pkg::SEQ_CMD;
  endproperty
  a_byp_short: assert property (p_byp_short) else $error("unlock sent in bypass");
  property p_count_word;
    st_q == ST_WLOW && op_q == nfpc_pkg::OP_BUF_PROGRAM && seq_q == nfpc_pkg::SEQ_ARG
      |-> pins_q.dq_out == {7'h00, cnt_q} && !pins_q.we_n;
  endproperty
  a_count_word: assert property (p_count_word) else $error("bad count word");
  property p_page;
    st_q == ST_WLOW && op_q == nfpc_pkg::OP_BUF_PROGRAM && seq_q == nfpc_pkg::SEQ_LOAD
      |-> pins_q.addr[22:9] == addr_q[22:9];
  endproperty
  a_page: assert property (p_page) else $error("load left the page");
  property p_confirm;
    $rose(seq_q == nfpc_pkg::SEQ_CONF) && op_q == nfpc_pkg::OP_BUF_PROGRAM
      |-> $past(idx_q) == cnt_q ##[2:4] pins_q.dq_out == nfpc_pkg::CMD_CONFIRM;
  endproperty
  a_confirm: assert property (p_confirm) else $error("confirm early or missing");
  property p_abort_reset;
    $rose(abort_q) |-> op_q == nfpc_pkg::OP_ABORT_RESET && seq_q == nfpc_pkg::SEQ_UNL1;
  endproperty
  a_abort_reset: assert property (p_abort_reset) else $error("short abort reset");
  property p_byp_buf;
    st_q == ST_STROBE && byp_eff && op_q == nfpc_pkg::OP_BUF_PROGRAM |-> seq_q >= nfpc_pkg::SEQ_CMD;
  endproperty
  a_byp_buf: assert property (p_byp_buf) else $error("unlock sent in bypass buffer");

  c_byp_enter: cover property ($rose(bypass_q));
  c_buf_done: cover property ($fell(busy_q) && op_q == nfpc_pkg::OP_BUF_PROGRAM && done_q);
  c_abort: cover property ($rose(abort_q));
  c_fail: cover property ($rose(fail_q));

endmodule // nfpc_ctrl

// >>> nfpc_flash_model.sv
`timescale 1ns/100ps
// Flash model that answers the controller's strobes
module nfpc_flash_model (
  input wire nfpc_pkg::nfpc_pins_type pins, // Controller pins
  input wire logic hv, // Protect pin at high voltage
  input wire logic force_abort, // Bench demands a buffer abort
  output logic [15:0] dq // Data pins toward controller
);
  logic [15:0] mem [int];
  logic [15:0] pend [int];
  logic [15:0] last = 16'h0000, hold = 16'h0000, rv, d;
  logic byp = 1'b0, ab = 1'b0, tog = 1'b0;
  int st = 0, busy = 0, left = 0, base = 0, n_wr = 0, a;
  function automatic logic [15:0] rd(input int x);
    return mem.exists(x) ? mem[x] : 16'hFFFF;
  endfunction
  // Command decode; codes outside the set fall back to idle
  task automatic cmd;
    st = 0;
    if (d == 16'h0020) byp = 1'b1;
    if (d == 16'h00A0) st = 3;
    if (d == 16'h0025)
    begin
      st = 4;
      base = a;
    end
    if (d == 16'h0090 && byp) st = 8;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // One bus write per rising write strobe with the chip enabled
  always @(posedge pins.we_n) if (!pins.ce_n)
  begin
    a = int'(pins.addr);
    d = pins.dq_out;
    n_wr++;
    if (ab)
    begin
      if (st == 2 && d == 16'h00F0) ab = 1'b0;
      st = (d == 16'h00AA) ? 1 : (st == 1 && d == 16'h0055) ? 2 : 0;
    end
    else case (st)
      0: if (d == 16'h00B0) busy = 0;
        else if (d == 16'h00AA) st = 1; else if (byp || hv) cmd;
      1: st = (d == 16'h0055) ? 2 : 0;
      2: cmd;
      3:
      begin
        mem[a] = rd(a) & d;
        last = d;
        busy = 3;
        st = 0;
      end
      4:
      begin
        left = int'(d);
        st = (d > 16'h01FF) ? 9 : 5;
        pend.delete();
      end
      5:
      begin
        pend[a] = d;
        last = d;
        if (a / 512 != base / 512) st = 9; else if (left-- == 0) st = 6;
      end
      6:
      begin
        st = 9;
        if (d == 16'h0029 && !force_abort)
        begin
          foreach (pend[k]) mem[k] = rd(k) & pend[k];
          busy = 3;
          st = 0;
        end
      end
      8:
      begin
        if (d == 16'h0000) byp = 1'b0;
        st = 0;
      end
      default: st = 0;
    endcase
    if (st == 9)
    begin
      ab = 1'b1;
      st = 0;
    end
  end
  // Status word while busy or aborted; a released bus shows the inverse of its last value
  always @*
  begin
    rv = ab ? {8'h00, ~last[7], tog, 4'h0, 2'b10} : busy > 0 ? {8'h00, ~last[7], tog, 6'h00}
      : rd(int'(pins.addr));
    dq = (pins.ce_n || pins.oe_n) ? ~hold : rv;
  end
  // End of a read moves the toggle bit and the busy count
  always @(posedge pins.oe_n)
  begin
    hold = rv;
    tog = ~tog;
    if (busy > 0) busy--;
  end
endmodule // nfpc_flash_model

// >>> tb.sv
`timescale 1ns/100ps
module tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fab = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, hv, err;
  logic [15:0] mdq, dq_in;
  nfpc_pkg::nfpc_pins_type pins;
  int n_fail = 0, n_tests = 0, w0;
  // Bus level resolved from the controller's enable
  assign dq_in = pins.dq_oe ? pins.dq_out : mdq;
  nfpc_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flash_pins(pins), .dq_in(dq_in), .accelerate_voltage_level(hv));
  nfpc_flash_model flash (.pins(pins), .hv(hv), .force_abort(fab), .dq(mdq));
  initial forever #5 pclk = ~pclk;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // Request held until the rising edge that samples pready high; answer taken there
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic op(input logic [31:0] c);
    w0 = flash.n_wr;
    apb(1'b1, 8'h00, c);
    repeat (400)
    begin
      apb(1'b0, 8'h04, 32'h0);
      if (q[0] === 1'b0) break;
    end
  endtask
  task automatic wrs(input int n);
    chk(32'(flash.n_wr - w0), 32'(n));
  endtask
  task automatic rdback(input logic [31:0] a);
    apb(1'b1, 8'h08, a);
    op(32'h7);
    apb(1'b0, 8'h1C, 32'h0);
  endtask
  task automatic t_prog;
    apb(1'b0, 8'h20, 32'h0);
    chk(32'(err), 32'h1);
    apb(1'b1, 8'h0C, 32'h1234);
    apb(1'b1, 8'h08, 32'h100);
    op(32'h3);
    wrs(4);
    chk(32'(q[2]), 32'h1);
    op(32'h1);
    chk(32'(q[1]), 32'h1);
    apb(1'b1, 8'h0C, 32'h0F0F);
    op(32'h3);
    wrs(2);
    rdback(32'h100);
    chk(q, 32'h0204);
    op(32'h5);
    chk(32'(q[1]), 32'h1);
    op(32'h2);
    wrs(2);
    chk(32'(q[1]), 32'h0);
  endtask
  task automatic t_buf(input logic [31:0] a, input int n, input int w);
    apb(1'b1, 8'h08, a);
    apb(1'b1, 8'h10, 32'(n));
    apb(1'b1, 8'h14, 32'h0);
    for (int i = 0; i <= n; i++) apb(1'b1, 8'h18, 32'hA5F0 >> i);
    op(32'h4);
    wrs(w);
  endtask
  // Read/reset first: it clears the sticky abort flag that would hold high voltage off
  task automatic t_hv;
    op(32'h5);
    apb(1'b1, 8'h00, 32'h100);
    apb(1'b0, 8'h04, 32'h0);
    chk(32'(hv), 32'h1);
    chk(32'(q[1]), 32'h1);
    apb(1'b1, 8'h08, 32'h500);
    op(32'h103);
    wrs(2);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    chk(32'(hv), 32'h0);
    chk(32'(q[7]), 32'h0);
    op(32'h203);
    wrs(5);
    chk(32'(q[6]), 32'h1);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_prog;
    t_buf(32'h200, 3, 9);
    rdback(32'h202);
    chk(q, 32'h297C);
    op(32'h1);
    t_buf(32'h200, 3, 7);
    op(32'h2);
    t_buf(32'h3FE, 3, 0);
    chk(32'(q[5]), 32'h1);
    fab <= 1'b1;
    t_buf(32'h400, 0, 9);
    chk(32'(q[4]), 32'h1);
    chk(32'(flash.ab), 32'h0);
    fab <= 1'b0;
    t_hv;
    end_of_test;
  end
  // Watchdog well past the expected run length
  initial
  begin
    repeat (80000) @(posedge pclk);
    n_fail++;
    end_of_test;
  end
endmodule // tb
